// File: cpu_seq_pkg.sv
// Constants, phase codes and operation codes for the fetch sequencer
package cpu_seq_pkg;
   // ==========================================
   // Widths
   localparam int IW = 14;
   localparam int AW = 10;
   localparam int DW = 8;
   localparam int STACK_DEPTH_DEF = 4;

   // ==========================================
   // Addresses, reset values and phase codes
   localparam logic [AW-1:0] RESET_VECTOR     = 10'h000;
   localparam logic [AW-1:0] IRQ_VECTOR_DEF   = 10'h004;
   localparam logic [DW-1:0] PC_LOW_BYTE_ADDR = 8'h06;
   localparam logic [3:0]    PHS_T1           = 4'h1;
   localparam logic [3:0]    PHS_T2           = 4'h2;
   localparam logic [3:0]    PHS_T3           = 4'h4;
   localparam logic [3:0]    PHS_T4           = 4'h8;

   // ==========================================
   // Instruction word fields
   localparam int            FLOW_MSB  = 13;
   localparam int            FLOW_LSB  = 10;
   localparam int            OP_MSB    = 13;
   localparam int            OP_LSB    = 8;
   localparam logic [3:0]    JUMP_CODE = 4'he;
   localparam logic [3:0]    CALL_CODE = 4'hf;

   // ==========================================
   // Types
   typedef enum logic [1:0] {T1 = 2'h0, T2 = 2'h1, T3 = 2'h3, T4 = 2'h2} phase_type;

   typedef enum logic [5:0] {
      OP_NOP, OP_ADD, OP_ADDM, OP_ADC, OP_ADCM, OP_SUB, OP_SUBM, OP_SBC, OP_SBCM,
      OP_DECIMAL_ADJUST, OP_AND, OP_OR, OP_XOR, OP_ANDM, OP_ORM, OP_XORM,
      OP_CPL, OP_CPLA, OP_RRA, OP_RR, OP_RRCA, OP_RRC, OP_RLA, OP_RL, OP_RLCA,
      OP_RLC, OP_INCA, OP_INC, OP_DECA, OP_DEC, OP_SKIP_IF_ZERO, OP_SKIP_ZA,
      OP_SKIP_IF_NONZERO, OP_SKIP_IZ, OP_SKIP_DZ, OP_SKIP_IZA, OP_SKIP_DZA,
      OP_MOVA, OP_MOVM, OP_RETURN_SUB, OP_RETURN_INT
   } op_type;
endpackage

// File: cpu_fetch_sequencer_stack.sv
// Fetch sequencer, return stack and ALU of the 8-bit core
// Contract
// - Four one-hot phases from the clock; one round is one instruction cycle.
// - Program counter advances entering phase one; word fetched during phase one.
// - Phases two to four decode and execute the previously fetched word.
// - Fetch overlaps execute, so plain instructions take one cycle each.
// - Jump and call take two cycles; second one refetches at the target.
// - Non-branching instructions step the program counter by one.
// - Jump, call, interrupt entry and reset load the counter directly.
// - A taken skip discards the fetched word and runs a dummy cycle.
// - Program counter is ten bits; only its low byte is software visible.
// - Writing the low byte jumps within the current 256-word page.
// - Writing the low byte inserts a dummy prefetch cycle.
// - Stack holds only return addresses and has no software access path.
// - Call or interrupt acknowledge pushes the return address.
// - Both return kinds pop the stack into the program counter.
// - Reset leaves the stack empty.
// - With a full stack interrupts wait unacknowledged until a return.
// - Call on a full stack still pushes and loses the oldest entry.
// - ALU is 8 bits, writes its destination and updates the flags.
// - Add, add with carry, subtract, subtract with borrow, decimal adjust.
// - And, or, exclusive or and complement, to accumulator or memory.
// - Rotates with and without carry, increment and decrement, both ways.
// - Jump, call, both returns and the zero, nonzero and count skips.
// - Reset loads the reset vector into the program counter.
// - Program memory is 1K words of 14 bits.
`timescale 1ns/1ps
module cpu_fetch_sequencer_stack
   import cpu_seq_pkg::*;
#(
   parameter int            STACK_DEPTH = STACK_DEPTH_DEF,
   parameter logic [AW-1:0] IRQ_VECTOR  = IRQ_VECTOR_DEF
) (
   // Clock and reset
   input  wire logic          ref_clk_in,
   input  wire logic          rst_in,
   // Program memory
   output logic [AW-1:0]      pm_addr_out,
   output logic               pm_rd_out,
   input  wire logic [IW-1:0] pm_data_in,
   // Data memory
   output logic [DW-1:0]      dm_addr_out,
   output logic               dm_rd_out,
   output logic               dm_wr_out,
   output logic [DW-1:0]      dm_wdata_out,
   input  wire logic [DW-1:0] dm_rdata_in,
   // Interrupt handshake
   input  wire logic          int_req_in,
   output logic               int_ack_out,
   // Status
   output logic [3:0]         instruction_phase_clocks_out,
   output logic [DW-1:0]      acc_out,
   output logic [2:0]         flags_out,
   output logic               stack_full_out,
   output logic               stack_overflow_out
);
   localparam int CW = $clog2(STACK_DEPTH + 1);

   // ==========================================
   // State
   typedef struct packed {
      phase_type                     ph;
      logic [3:0]                    phs;
      logic [AW-1:0]                 pc;
      logic                          pm_rd;
      logic [IW-1:0]                 ir;
      logic                          ok;
      logic [IW-1:0]                 fet;
      logic [DW-1:0]                 opnd;
      logic [DW-1:0]                 acc;
      logic                          c;
      logic                          z;
      logic                          ac;
      logic [DW-1:0]                 dma;
      logic                          dmr;
      logic                          dmw;
      logic [DW-1:0]                 dmd;
      logic                          chg;
      logic                          pclw;
      logic [AW-1:0]                 tgt;
      logic                          push;
      logic                          pop;
      logic                          ack;
      logic [STACK_DEPTH-1:0][AW-1:0] stk;
      logic [CW-1:0]                 cnt;
      logic                          full;
      logic                          ovf;
   } state_type;

   state_type st_q;
   state_type st_d;
   logic      take;

   // ==========================================
   // Helpers
   function automatic logic is_flow(input logic [IW-1:0] w);
      return (w[FLOW_MSB:FLOW_LSB] == JUMP_CODE) || (w[FLOW_MSB:FLOW_LSB] == CALL_CODE);
   endfunction

   function automatic logic [9:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       ci);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      return {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction

   function automatic logic [9:0] dadj(input logic [7:0] a,
                                       input logic       ci,
                                       input logic       aci);
      logic [8:0] t;
      t = {1'b0, a};
      if (a[3:0] > 4'h9 || aci) begin
         t = t + 9'h006;
      end
      if (t[7:4] > 4'h9 || ci || t[8]) begin
         t = t + 9'h060;
      end
      return {t[8] | ci, aci, t[7:0]};
   endfunction

   // Interrupt entry waits while the stack is full
   assign take = (st_q.ph == T4) && int_req_in && st_q.ok && !st_q.chg && !st_q.full;

   // ==========================================
   // Next state
   always_comb begin
      op_type     op;
      logic [7:0] m;
      logic [9:0] ar;
      logic       wr;
      logic       wm;
      logic       wa;
      logic       sk;
      st_d = st_q;
      op   = op_type'(st_q.ir[OP_MSB:OP_LSB]);
      m    = st_q.opnd;
      ar   = {st_q.c, st_q.ac, st_q.acc};
      wr   = 1'b0;
      wm   = 1'b0;
      wa   = 1'b0;
      sk   = 1'b0;
      st_d.ack = 1'b0;
      st_d.ovf = 1'b0;
      unique case (st_q.ph)
         T1: begin
            st_d.ph    = T2;
            st_d.phs   = PHS_T2;
            st_d.pm_rd = 1'b0;
            st_d.fet   = pm_data_in;
            if (st_q.ok && !is_flow(st_q.ir)
                && !(op inside {OP_NOP, OP_RETURN_SUB, OP_RETURN_INT})) begin
               st_d.dma = st_q.ir[DW-1:0];
               st_d.dmr = 1'b1;
            end
         end
         T2: begin
            st_d.ph  = T3;
            st_d.phs = PHS_T3;
            st_d.dmr = 1'b0;
            // Low byte of the counter reads back through the data path
            if (st_q.dma == PC_LOW_BYTE_ADDR) begin
               st_d.opnd = st_q.pc[DW-1:0];
            end else begin
               st_d.opnd = dm_rdata_in;
            end
         end
         T3: begin
            st_d.ph  = T4;
            st_d.phs = PHS_T4;
            if (st_q.ok && is_flow(st_q.ir)) begin
               st_d.chg  = 1'b1;
               st_d.tgt  = st_q.ir[AW-1:0];
               st_d.push = (st_q.ir[FLOW_MSB:FLOW_LSB] == CALL_CODE);
            end
            wr = st_q.ok && !is_flow(st_q.ir);
            if (wr) begin
               unique case (op)
                  OP_ADD, OP_ADDM:   ar = add8(st_q.acc, m, 1'b0);
                  OP_ADC, OP_ADCM:   ar = add8(st_q.acc, m, st_q.c);
                  OP_SUB, OP_SUBM:   ar = add8(st_q.acc, ~m, 1'b1);
                  OP_SBC, OP_SBCM:   ar = add8(st_q.acc, ~m, st_q.c);
                  OP_DECIMAL_ADJUST: ar = dadj(st_q.acc, st_q.c, st_q.ac);
                  OP_AND, OP_ANDM:   ar = {st_q.c, st_q.ac, st_q.acc & m};
                  OP_OR, OP_ORM:     ar = {st_q.c, st_q.ac, st_q.acc | m};
                  OP_XOR, OP_XORM:   ar = {st_q.c, st_q.ac, st_q.acc ^ m};
                  OP_CPL, OP_CPLA:   ar = {st_q.c, st_q.ac, ~m};
                  OP_RRA, OP_RR:     ar = {st_q.c, st_q.ac, m[0], m[7:1]};
                  OP_RRCA, OP_RRC:   ar = {m[0], st_q.ac, st_q.c, m[7:1]};
                  OP_RLA, OP_RL:     ar = {st_q.c, st_q.ac, m[6:0], m[7]};
                  OP_RLCA, OP_RLC:   ar = {m[7], st_q.ac, m[6:0], st_q.c};
                  OP_INCA, OP_INC, OP_SKIP_IZ, OP_SKIP_IZA: begin
                     ar = {st_q.c, st_q.ac, m + 8'h01};
                  end
                  OP_DECA, OP_DEC, OP_SKIP_DZ, OP_SKIP_DZA: begin
                     ar = {st_q.c, st_q.ac, m - 8'h01};
                  end
                  OP_MOVA, OP_SKIP_IF_ZERO, OP_SKIP_IF_NONZERO, OP_SKIP_ZA: begin
                     ar = {st_q.c, st_q.ac, m};
                  end
                  OP_MOVM: ar = {st_q.c, st_q.ac, st_q.acc};
                  OP_RETURN_SUB, OP_RETURN_INT: begin
                     wr       = 1'b0;
                     st_d.chg = 1'b1;
                     st_d.pop = 1'b1;
                     st_d.tgt = st_q.stk[0];
                  end
                  default: wr = 1'b0;
               endcase
            end
            wm = op inside {OP_ADDM, OP_ADCM, OP_SUBM, OP_SBCM, OP_DECIMAL_ADJUST,
                            OP_ANDM, OP_ORM, OP_XORM, OP_CPL, OP_RR, OP_RRC, OP_RL,
                            OP_RLC, OP_INC, OP_DEC, OP_SKIP_IZ, OP_SKIP_DZ, OP_MOVM};
            wa = !wm && !(op inside {OP_SKIP_IF_ZERO, OP_SKIP_IF_NONZERO});
            if (op inside {OP_SKIP_IF_ZERO, OP_SKIP_ZA, OP_SKIP_IZ, OP_SKIP_DZ,
                           OP_SKIP_IZA, OP_SKIP_DZA}) begin
               sk = (ar[7:0] == 8'h00);
            end
            if (op == OP_SKIP_IF_NONZERO) begin
               sk = (ar[7:0] != 8'h00);
            end
            if (wr) begin
               st_d.c  = ar[9];
               st_d.ac = ar[8];
               if (!(op inside {OP_RRA, OP_RR, OP_RRCA, OP_RRC, OP_RLA, OP_RL, OP_RLCA,
                                OP_RLC, OP_MOVA, OP_MOVM, OP_SKIP_IF_ZERO, OP_SKIP_ZA,
                                OP_SKIP_IF_NONZERO, OP_SKIP_IZ, OP_SKIP_DZ, OP_SKIP_IZA,
                                OP_SKIP_DZA})) begin
                  st_d.z = (ar[7:0] == 8'h00);
               end
               if (wa) begin
                  st_d.acc = ar[7:0];
               end
               if (wm && st_q.dma == PC_LOW_BYTE_ADDR) begin
                  st_d.chg  = 1'b1;
                  st_d.pclw = 1'b1;
                  st_d.tgt  = {st_q.pc[AW-1:DW], ar[7:0]};
               end else if (wm) begin
                  st_d.dmw = 1'b1;
                  st_d.dmd = ar[7:0];
               end
               if (sk) begin
                  st_d.chg = 1'b1;
                  st_d.tgt = st_q.pc + 10'h001;
               end
            end
         end
         T4: begin
            st_d.ph    = T1;
            st_d.phs   = PHS_T1;
            st_d.pm_rd = 1'b1;
            st_d.dmw   = 1'b0;
            st_d.ir    = st_q.fet;
            st_d.ok    = !st_q.chg && !take;
            st_d.chg   = 1'b0;
            st_d.pclw  = 1'b0;
            st_d.push  = 1'b0;
            st_d.pop   = 1'b0;
            if (take) begin
               st_d.pc  = IRQ_VECTOR;
               st_d.ack = 1'b1;
            end else if (st_q.chg) begin
               st_d.pc = st_q.tgt;
            end else begin
               st_d.pc = st_q.pc + 10'h001;
            end
            // Stack lives only here, never on the data bus
            if (st_q.push || take) begin
               st_d.stk = {st_q.stk[STACK_DEPTH-2:0], st_q.pc};
               st_d.ovf = st_q.full;
               if (!st_q.full) begin
                  st_d.cnt = st_q.cnt + CW'(1);
               end
            end else if (st_q.pop && st_q.cnt != '0) begin
               st_d.stk = {AW'(0), st_q.stk[STACK_DEPTH-1:1]};
               st_d.cnt = st_q.cnt - CW'(1);
            end
            st_d.full = (st_d.cnt == CW'(STACK_DEPTH));
         end
      endcase
   end

   // ==========================================
   // Registers
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         st_q       <= '0;
         st_q.ph    <= T1;
         st_q.phs   <= PHS_T1;
         st_q.pm_rd <= 1'b1;
         st_q.pc    <= RESET_VECTOR;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // Outputs
   assign pm_addr_out                  = st_q.pc;
   assign pm_rd_out                    = st_q.pm_rd;
   assign dm_addr_out                  = st_q.dma;
   assign dm_rd_out                    = st_q.dmr;
   assign dm_wr_out                    = st_q.dmw;
   assign dm_wdata_out                 = st_q.dmd;
   assign int_ack_out                  = st_q.ack;
   assign instruction_phase_clocks_out = st_q.phs;
   assign acc_out                      = st_q.acc;
   assign flags_out                    = {st_q.ac, st_q.z, st_q.c};
   assign stack_full_out               = st_q.full;
   assign stack_overflow_out           = st_q.ovf;

   // ==========================================
   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_exec;
      st_q.ph == T2 ##1 st_q.ph == T3 ##1 st_q.ph == T4;
   endsequence

   sequence s_dummy_then_live;
      !st_q.ok ##4 st_q.ok;
   endsequence

   AST_PHASE_RING: assert property (
      st_q.ph == T1 |=> s_exec ##1 st_q.ph == T1)
      else $error("phase ring broken");
   AST_FETCH_T1: assert property (
      st_q.ph == T1 |=> st_q.fet == $past(pm_data_in) ##0 !pm_rd_out [*3] ##1 pm_rd_out)
      else $error("fetch not in phase one");
   AST_PC_STEP: assert property (
      st_q.ph == T4 && !st_q.chg && !take |=> st_q.pc == $past(st_q.pc) + 10'h001)
      else $error("counter did not step by one");
   AST_BRANCH_LOAD: assert property (
      st_q.ph == T4 && st_q.chg |=> st_q.pc == $past(st_q.tgt) ##0 s_dummy_then_live)
      else $error("branch load or dummy cycle wrong");
   AST_PAGE_WRITE: assert property (
      st_q.ph == T4 && st_q.pclw |-> !dm_wr_out ##1 st_q.pc[9:8] == $past(st_q.pc[9:8]))
      else $error("low byte write left the page");
   AST_PUSH: assert property (
      st_q.ph == T4 && (st_q.push || take) |=> st_q.stk[0] == $past(st_q.pc))
      else $error("return address not pushed");
   AST_POP: assert property (
      st_q.ph == T4 && st_q.pop && st_q.cnt != '0
      |=> st_q.pc == $past(st_q.stk[0]) && st_q.cnt == $past(st_q.cnt) - CW'(1))
      else $error("return did not pop");
   AST_FULL_HOLD: assert property (
      st_q.full && st_q.ph == T4
      |=> !int_ack_out && (st_q.cnt == $past(st_q.cnt) || $past(st_q.pop)))
      else $error("interrupt taken with full stack");
   AST_OVERFLOW: assert property (
      st_q.ph == T4 && st_q.push && st_q.full
      |=> st_q.full && stack_overflow_out
          && st_q.stk[STACK_DEPTH-1] == $past(st_q.stk[STACK_DEPTH-2]))
      else $error("overflow push wrong");
   AST_RESET_STATE: assert property (
      $past(rst_in) |-> st_q.pc == RESET_VECTOR && st_q.cnt == '0 && !stack_full_out)
      else $error("reset state wrong");
endmodule

// File: prog_mem_model.sv
// Program memory model answering instruction fetches
`timescale 1ns/1ps
module prog_mem_model
   import cpu_seq_pkg::*;
(
   // Fetch port
   input  wire logic [AW-1:0] addr_in,
   input  wire logic          rd_in,
   output logic [IW-1:0]      data_out
);
   // ==========================================
   // Storage, loaded by the bench
   logic [IW-1:0] mem [0:(1<<AW)-1];

   // ==========================================
   // Word valid while fetch strobe high, inverted otherwise
   always_comb begin
      data_out = rd_in ? mem[addr_in] : ~mem[addr_in];
   end
endmodule

// File: cpu_fetch_sequencer_stack_tb_top.sv
// Self-checking bench for the fetch sequencer and return stack
`timescale 1ns/1ps
module cpu_fetch_sequencer_stack_tb_top
   import cpu_seq_pkg::*;
   ;
   // ==========================================
   // Signals
   logic          ref_clk_in;
   logic          rst_in;
   logic [AW-1:0] pm_addr_out;
   logic          pm_rd_out;
   logic [IW-1:0] pm_data_in;
   logic [DW-1:0] dm_addr_out;
   logic          dm_rd_out;
   logic          dm_wr_out;
   logic [DW-1:0] dm_wdata_out;
   logic [DW-1:0] dm_rdata_in;
   logic          int_req_in;
   logic          int_ack_out;
   logic          stack_full_out;
   logic          stack_overflow_out;
   logic [3:0]    instruction_phase_clocks_out;
   logic [DW-1:0] acc_out;
   logic [2:0]    flags_out;
   logic [DW-1:0] dmem [0:255];
   logic [12:0]   exp_fetch_q [$];
   logic [15:0]   exp_wr_q [$];
   logic [12:0]   got_f;
   logic [15:0]   exp_w;
   logic [1:0]    ph_cnt;
   logic [8:0]    s9;
   logic [4:0]    s5;
   logic [7:0]    a_e;
   logic          c_e;
   logic [10:0]   exp_st;
   int            num_errors;
   int            checked;
   int            cycles;

   // ==========================================
   // Clock, models and design
   initial ref_clk_in = 1'b0;
   always #25 ref_clk_in = ~ref_clk_in;

   assign dm_rdata_in = dm_rd_out ? dmem[dm_addr_out] : ~dmem[dm_addr_out] ^ cycles[7:0];

   prog_mem_model pm (
      .addr_in  (pm_addr_out),
      .rd_in    (pm_rd_out),
      .data_out (pm_data_in)
   );

   cpu_fetch_sequencer_stack #(.STACK_DEPTH(2), .IRQ_VECTOR(10'h0c0)) dut (
      .ref_clk_in                   (ref_clk_in),
      .rst_in                       (rst_in),
      .pm_addr_out                  (pm_addr_out),
      .pm_rd_out                    (pm_rd_out),
      .pm_data_in                   (pm_data_in),
      .dm_addr_out                  (dm_addr_out),
      .dm_rd_out                    (dm_rd_out),
      .dm_wr_out                    (dm_wr_out),
      .dm_wdata_out                 (dm_wdata_out),
      .dm_rdata_in                  (dm_rdata_in),
      .int_req_in                   (int_req_in),
      .int_ack_out                  (int_ack_out),
      .instruction_phase_clocks_out (instruction_phase_clocks_out),
      .acc_out                      (acc_out),
      .flags_out                    (flags_out),
      .stack_full_out               (stack_full_out),
      .stack_overflow_out           (stack_overflow_out)
   );

   // ==========================================
   // Helpers
   function automatic logic [IW-1:0] opw(op_type op, logic [7:0] m);
      return {op, m};
   endfunction

   function automatic logic [IW-1:0] brw(logic [3:0] code, logic [AW-1:0] t);
      return {code, t};
   endfunction

   task automatic ef(logic [AW-1:0] a, logic f = 1'b0, logic o = 1'b0, logic k = 1'b0);
      exp_fetch_q.push_back({f, o, k, a});
   endtask

   task automatic ew(logic [7:0] a, logic [7:0] d);
      exp_wr_q.push_back({a, d});
   endtask

   task automatic cmp_fetch(logic [12:0] exp, logic [12:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t fetch exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_write(logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t write exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_phase(logic [3:0] exp, logic [3:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t phase exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic cmp_state(logic [10:0] exp, logic [10:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t state exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // Result watcher
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (rst_in) begin
         ph_cnt <= 2'h0;
      end else begin
         cmp_phase(4'h1 << ph_cnt, instruction_phase_clocks_out);
         ph_cnt <= ph_cnt + 2'h1;
      end
      if (!rst_in && pm_rd_out === 1'b1 && exp_fetch_q.size() > 0) begin
         got_f = {stack_full_out, stack_overflow_out, int_ack_out, pm_addr_out};
         cmp_fetch(exp_fetch_q.pop_front(), got_f);
      end
      if (!rst_in && dm_wr_out !== 1'b0) begin
         exp_w = (exp_wr_q.size() > 0) ? exp_wr_q.pop_front() : 16'hxxxx;
         cmp_write(exp_w, {dm_addr_out, dm_wdata_out});
         dmem[dm_addr_out] <= dm_wdata_out;
      end
      if (cycles >= 1000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ==========================================
   // Stimulus
   initial begin
      rst_in = 1'b1;
      int_req_in = 1'b0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      void'($urandom(32'hacda136b));
      for (int i = 0; i < 256; i++) dmem[i] = 8'($urandom());
      dmem[8'h15] = 8'h00;
      dmem[8'h18] = 8'h01;
      for (int i = 0; i < 1024; i++) pm.mem[i] = opw(OP_NOP, 8'h00);
      pm.mem[10'h000] = opw(OP_ADD, 8'h10);
      pm.mem[10'h001] = opw(OP_ADDM, 8'h11);
      pm.mem[10'h002] = opw(OP_XORM, 8'h12);
      pm.mem[10'h003] = opw(OP_CPL, 8'h13);
      pm.mem[10'h004] = opw(OP_INC, 8'h14);
      pm.mem[10'h005] = opw(OP_SKIP_IF_ZERO, 8'h15);
      pm.mem[10'h006] = opw(OP_INC, 8'h16);
      pm.mem[10'h007] = opw(OP_SKIP_IF_NONZERO, 8'h15);
      pm.mem[10'h008] = opw(OP_DEC, 8'h17);
      pm.mem[10'h009] = brw(CALL_CODE, 10'h100);
      pm.mem[10'h100] = opw(OP_SKIP_DZ, 8'h18);
      pm.mem[10'h101] = opw(OP_INC, 8'h19);
      pm.mem[10'h102] = brw(CALL_CODE, 10'h200);
      pm.mem[10'h200] = brw(CALL_CODE, 10'h280);
      pm.mem[10'h280] = opw(OP_RETURN_SUB, 8'h00);
      pm.mem[10'h201] = opw(OP_RETURN_SUB, 8'h00);
      pm.mem[10'h103] = opw(OP_CPL, PC_LOW_BYTE_ADDR);
      pm.mem[10'h1fb] = brw(JUMP_CODE, 10'h300);
      pm.mem[10'h300] = brw(CALL_CODE, 10'h340);
      pm.mem[10'h340] = brw(CALL_CODE, 10'h380);
      pm.mem[10'h382] = opw(OP_RETURN_SUB, 8'h00);
      pm.mem[10'h0c0] = opw(OP_RETURN_INT, 8'h00);
      pm.mem[10'h343] = opw(OP_SUBM, 8'h1a);
      pm.mem[10'h344] = opw(OP_SBCM, 8'h1b);
      pm.mem[10'h345] = opw(OP_ADCM, 8'h1c);
      pm.mem[10'h346] = opw(OP_ANDM, 8'h1d);
      pm.mem[10'h347] = opw(OP_ORM, 8'h1e);
      pm.mem[10'h348] = opw(OP_RRC, 8'h1f);
      pm.mem[10'h349] = opw(OP_RLC, 8'h20);
      pm.mem[10'h34a] = opw(OP_RL, 8'h21);
      pm.mem[10'h34b] = opw(OP_RR, 8'h22);
      // Expected data writes
      ew(8'h11, dmem[8'h10] + dmem[8'h11]);
      ew(8'h12, dmem[8'h10] ^ dmem[8'h12]);
      ew(8'h13, ~dmem[8'h13]);
      ew(8'h14, dmem[8'h14] + 8'h01);
      ew(8'h17, dmem[8'h17] - 8'h01);
      ew(8'h18, 8'h00);
      a_e = dmem[8'h10];
      ew(8'h1a, a_e - dmem[8'h1a]);
      c_e = a_e >= dmem[8'h1a];
      ew(8'h1b, a_e - dmem[8'h1b] - {7'h00, !c_e});
      c_e = {1'b0, a_e} >= {1'b0, dmem[8'h1b]} + {8'h00, !c_e};
      s9 = {1'b0, a_e} + {1'b0, dmem[8'h1c]} + {8'h00, c_e};
      s5 = {1'b0, a_e[3:0]} + {1'b0, dmem[8'h1c][3:0]} + {4'h0, c_e};
      ew(8'h1c, s9[7:0]);
      ew(8'h1d, a_e & dmem[8'h1d]);
      ew(8'h1e, a_e | dmem[8'h1e]);
      ew(8'h1f, {s9[8], dmem[8'h1f][7:1]});
      ew(8'h20, {dmem[8'h20][6:0], dmem[8'h1f][0]});
      ew(8'h21, {dmem[8'h21][6:0], dmem[8'h21][7]});
      ew(8'h22, {dmem[8'h22][0], dmem[8'h22][7:1]});
      exp_st = {a_e, s5[4], (a_e | dmem[8'h1e]) == 8'h00, dmem[8'h20][7]};
      // Expected fetch trace
      for (int a = 0; a < 11; a++) ef(10'(a));
      ef(10'h100);
      ef(10'h101);
      ef(10'h102);
      ef(10'h103);
      ef(10'h200, 1'b1);
      ef(10'h201, 1'b1);
      ef(10'h280, 1'b1, 1'b1);
      ef(10'h281, 1'b1);
      ef(10'h201);
      ef(10'h202);
      ef(10'h103);
      ef(10'h104);
      ef(10'h1fb);
      ef(10'h1fc);
      ef(10'h300);
      ef(10'h301);
      ef(10'h340);
      ef(10'h341);
      ef(10'h380, 1'b1);
      ef(10'h381, 1'b1);
      ef(10'h382, 1'b1);
      ef(10'h383, 1'b1);
      ef(10'h341);
      ef(10'h342);
      ef(10'h0c0, 1'b1, 1'b0, 1'b1);
      ef(10'h0c1, 1'b1);
      ef(10'h342);
      ef(10'h343);
      for (int a = 32'h344; a < 32'h34d; a++) ef(10'(a));
      repeat (3) @(negedge ref_clk_in);
      rst_in = 1'b0;
      for (int i = 0; i < 400 && !(pm_rd_out === 1'b1 && pm_addr_out === 10'h381); i++) begin
         @(negedge ref_clk_in);
      end
      int_req_in = 1'b1;
      for (int i = 0; i < 100 && int_ack_out !== 1'b1; i++) begin
         @(negedge ref_clk_in);
      end
      int_req_in = 1'b0;
      for (int i = 0; i < 400 && exp_fetch_q.size() > 0; i++) begin
         @(negedge ref_clk_in);
      end
      repeat (8) @(negedge ref_clk_in);
      cmp_state(exp_st, {acc_out, flags_out});
      if (exp_fetch_q.size() + exp_wr_q.size() != 0) begin
         num_errors++;
         $display("ERROR t=%0t results missing exp=%h got=%h", $time, 0,
                  exp_fetch_q.size() + exp_wr_q.size());
      end
      report_and_stop();
   end
endmodule
